// file: src/rtu_sensor_regs.svh
// Register numbers, field limits, reset values and timing figures of the sensor node.
// Assumes inclusion by bare name from files that also compile rtu_cfg_pkg.
`ifndef RTU_SENSOR_REGS_SVH
`define RTU_SENSOR_REGS_SVH

// Holding register numbers as the master sees them, in decimal terms (0x9c41 = 40001).
`define REG_NODE_ADDR     16'h9c41
`define REG_LINE_SETUP    16'h9c42
`define REG_DELAYS        16'h9c43
`define REG_CONV_STATUS   16'h9c70
`define REG_CHAN0_DATA    16'h9c71
// Protocol address of a register is its number less the first register number.
`define PDU_OF(n)         ((n) - 16'h9c41)

// Reset values of the settable registers.
`define RST_NODE_ADDR     16'h0001
`define RST_LINE_SETUP    16'h0035
`define RST_DELAYS        16'h0003

// Field limits.
`define NODE_ADDR_MIN     16'h0001
`define NODE_ADDR_MAX     16'h00df
`define BAUD_CODE_MIN     5'h05
`define BAUD_CODE_MAX     5'h09
`define RESP_DELAY_MAX    8'h3f
`define EOQ_DELAY_MAX     8'h30
`define FRAME_MODE_8N1    2'h3

// Function and exception codes, and frame sizes.
`define FN_READ_HOLD      8'h03
`define FN_WRITE_ONE      8'h06
`define FN_EXC_FLAG       8'h80
`define EXC_BAD_FN        8'h01
`define EXC_BAD_ADDR      8'h02
`define EXC_BAD_VALUE     8'h03
`define REQ_BYTES         4'h8
`define MAX_READ_WORDS    16'h0010
`define CRC_INIT          16'hffff
`define CRC_POLY          16'ha001

// Timing: clock, conversions, silence and milliseconds.
`define CLK_HZ            40000000
`define CONV_PER_SEC      25
`define MS_PER_SEC        1000
`define T35_BIT_TIMES     39

`endif

// file: src/rtu_cfg_pkg.sv
// Types shared by the sensor node, its checker and its bench.
// Assumes rtu_sensor_regs.svh for all numeric constants.
`default_nettype none
package rtu_cfg_pkg;
  // The three settable registers, kept and restored as one word.
  typedef struct packed {
    logic [15:0] delays;
    logic [15:0] line_setup;
    logic [15:0] node_addr;
  } cfg_type;

  // Kind of reply that the node builds.
  typedef enum logic [1:0] {RSP_READ, RSP_ECHO, RSP_EXC} rsp_kind_type;

  // Request handling sequence.
  typedef enum logic [2:0] {ST_RX, ST_EXEC, ST_WAIT, ST_SEND, ST_DRAIN} state_type;
endpackage
`default_nettype wire

// file: src/rtu_serial_port.sv
// Character-level serial port: one receiver and one transmitter, 8 data bits.
// Assumes rxd is already synchronised to clk and div is clocks per bit time.
`include "rtu_sensor_regs.svh"
`default_nettype none
module rtu_serial_port #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [DIV_W-1:0] div,
  input  wire logic [1:0]       frame_mode,
  input  wire logic             rxd,
  output logic                  rx_valid,
  output logic [7:0]            rx_data,
  output logic                  rx_err,
  input  wire logic             tx_start,
  input  wire logic [7:0]       tx_data,
  output logic                  tx_busy,
  output logic                  txd
);
  logic             has_par;   // Parity bit present (modes 1 and 2).
  logic [3:0]       nbits;     // Bits in one character, start and stop included.
  logic [DIV_W-1:0] rx_cnt_r;  // Cycles to the next receive sample.
  logic [3:0]       rx_idx_r;  // Index of the bit to sample next.
  logic             rx_on_r;   // Receiver inside a character.
  logic [7:0]       rx_sh_r;   // Data bits gathered so far.
  logic             rx_bad_r;  // Parity or stop fault seen in this character.
  logic [10:0]      tx_sh_r;   // Bits still to send, LSB next.
  logic [3:0]       tx_left_r; // Bits remaining, current one included.
  logic [DIV_W-1:0] tx_cnt_r;  // Cycles left in the current bit.

  // Framing: modes 1 and 2 carry parity and one stop, mode 3 one stop, mode 0 two stops.
  assign has_par = (frame_mode == 2'h1) || (frame_mode == 2'h2);
  assign nbits   = (frame_mode == `FRAME_MODE_8N1) ? 4'ha : 4'hb;
  assign tx_busy = (tx_left_r != 4'h0);

  // Parity bit for a byte under the current mode; odd when mode is 1.
  function automatic logic par_of(input logic [7:0] d, input logic [1:0] m);
    par_of = (^d) ^ (m == 2'h1);
  endfunction

  // Receiver: samples mid-bit, checks start, parity and every stop bit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_r <= '0;
      rx_idx_r <= 4'h0;
      rx_on_r  <= 1'b0;
      rx_sh_r  <= 8'h00;
      rx_bad_r <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      rx_err   <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_on_r) begin
        // A low level on an idle line starts a character; sample half a bit later.
        if (!rxd) begin
          rx_on_r  <= 1'b1;
          rx_idx_r <= 4'h0;
          rx_bad_r <= 1'b0;
          rx_cnt_r <= div >> 1;
        end
      end else if (rx_cnt_r != '0) begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end else begin
        rx_cnt_r <= div - 1'b1;
        rx_idx_r <= rx_idx_r + 4'h1;
        if (rx_idx_r == 4'h0) begin
          // A glitch that is gone by mid start bit is not a character.
          if (rxd) rx_on_r <= 1'b0;
        end else if (rx_idx_r <= 4'h8) begin
          rx_sh_r <= {rxd, rx_sh_r[7:1]};
        end else if (rx_idx_r == 4'h9 && has_par) begin
          if (rxd != par_of(rx_sh_r, frame_mode)) rx_bad_r <= 1'b1;
        end else if (!rxd) begin
          rx_bad_r <= 1'b1;
        end
        // The last stop bit closes the character.
        if (rx_idx_r == nbits - 4'h1) begin
          rx_on_r  <= 1'b0;
          rx_valid <= 1'b1;
          rx_data  <= rx_sh_r;
          rx_err   <= rx_bad_r || !rxd;
        end
      end
    end
  end

  // Transmitter: loads a whole character and shifts it out LSB first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_r   <= '1;
      tx_left_r <= 4'h0;
      tx_cnt_r  <= '0;
      txd       <= 1'b1;
    end else if (tx_left_r == 4'h0) begin
      if (tx_start) begin
        txd       <= 1'b0;
        tx_sh_r   <= {2'b11, has_par ? par_of(tx_data, frame_mode) : 1'b1, tx_data};
        tx_left_r <= nbits;
        tx_cnt_r  <= div - 1'b1;
      end
    end else if (tx_cnt_r != '0) begin
      tx_cnt_r <= tx_cnt_r - 1'b1;
    end else begin
      tx_left_r <= tx_left_r - 4'h1;
      tx_cnt_r  <= div - 1'b1;
      // The line rests high once the last stop bit has run its time.
      txd       <= (tx_left_r == 4'h1) ? 1'b1 : tx_sh_r[0];
      tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
    end
  end
endmodule
`default_nettype wire

// file: src/rtu_sensor_node.sv
// Sensor node: three-channel conversion buffer answering an RTU master over RS-485.
// Assumes a same-clock converter handshake and a same-clock nonvolatile store.
`include "rtu_sensor_regs.svh"
`default_nettype none
module rtu_sensor_node #(
  parameter int CLK_HZ     = `CLK_HZ,
  parameter int MS_CYCLES  = `CLK_HZ / `MS_PER_SEC,
  parameter int CONV_CYCLES = `CLK_HZ / `CONV_PER_SEC,
  parameter int NCHAN      = 3
) (
  input  wire logic                  MCLK,
  input  wire logic                  RST_N,
  input  wire logic                  RXD,
  output logic                       TXD,
  output logic                       TX_EN,
  output logic                       ADC_START,
  output logic [1:0]                 ADC_CHAN,
  input  wire logic                  ADC_DONE,
  input  wire logic [15:0]           ADC_RESULT,
  input  wire logic                  NV_LOAD,
  input  wire rtu_cfg_pkg::cfg_type  NV_CFG_IN,
  output logic                       NV_SAVE,
  output rtu_cfg_pkg::cfg_type       NV_CFG_OUT
);
  rtu_cfg_pkg::cfg_type      cfg_r;                // Live settings.
  logic [15:0]               data_r [NCHAN];       // Newest result per channel.
  logic [7:0]                conv_cnt_r;           // Conversion counter.
  logic [2:0]                last_chan_r;          // Channel of the newest result.
  logic [31:0]               conv_tmr_r;           // Cycles since the last conversion start.
  logic                      rxd_s1_r, rxd_s2_r;   // Line synchroniser.
  logic [7:0]                rxb_r [8];            // Request bytes.
  logic [3:0]                rx_n_r;               // Request bytes seen, saturating.
  logic                      rx_bad_r;             // Character fault or overlong frame.
  logic [15:0]               rx_crc_r;             // Running check over the request.
  logic [23:0]               tmr_r;                // Silence and delay timer.
  rtu_cfg_pkg::state_type    st_r;                 // Request sequence.
  rtu_cfg_pkg::rsp_kind_type kind_r;               // Reply being sent.
  logic [7:0]                code_r;               // Exception code.
  logic [5:0]                len_r;                // Reply bytes before the check word.
  logic [5:0]                idx_r;                // Reply byte being sent.
  logic [15:0]               tx_crc_r;             // Running check over the reply.
  logic                      tx_go_r;              // One-cycle character start.
  logic [7:0]                tx_byte_r;            // Character to send.
  logic [15:0]               div;                  // Clocks per bit time.
  logic                      rx_valid, rx_err, tx_busy;
  logic [7:0]                rx_data;
  logic [15:0]               req_addr, req_val;    // Register address and value or count.
  logic [23:0]               sil_lim;              // Silence that ends a request.
  logic                      frame_ok;             // Request is whole, sound and ours.
  rtu_cfg_pkg::rsp_kind_type ex_kind;              // Decoded reply kind.
  logic [7:0]                ex_code;              // Decoded exception code.
  logic                      ex_wr;                // Decoded register write.
  logic [7:0]                nxt_byte;             // Next reply byte.

  // One step of the reflected check sequence.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    return r;
  endfunction

  // Value read at a protocol address; unmapped addresses inside the range read as zero.
  function automatic logic [15:0] reg_read(input logic [15:0] a);
    logic [15:0] c;
    c = a - 16'(`PDU_OF(`REG_CHAN0_DATA));
    if (a == 16'(`PDU_OF(`REG_NODE_ADDR)))            return cfg_r.node_addr;
    else if (a == 16'(`PDU_OF(`REG_LINE_SETUP)))      return cfg_r.line_setup;
    else if (a == 16'(`PDU_OF(`REG_DELAYS)))          return cfg_r.delays;
    else if (a == 16'(`PDU_OF(`REG_CONV_STATUS)))     return {5'h00, last_chan_r, conv_cnt_r};
    else if (a >= 16'(`PDU_OF(`REG_CHAN0_DATA)) && c < 16'(NCHAN)) return data_r[c[1:0]];
    else                                              return 16'h0000;
  endfunction

  // Whether a value may go into a settable register.
  function automatic logic wr_ok(input logic [15:0] a, input logic [15:0] v);
    if (a == 16'(`PDU_OF(`REG_NODE_ADDR)))
      return v >= `NODE_ADDR_MIN && v <= `NODE_ADDR_MAX;
    else if (a == 16'(`PDU_OF(`REG_LINE_SETUP)))
      return v[4:0] >= `BAUD_CODE_MIN && v[4:0] <= `BAUD_CODE_MAX;
    else
      return v[7:0] <= `RESP_DELAY_MAX && v[15:8] <= `EOQ_DELAY_MAX;
  endfunction

  // Clocks per bit for a baud code.
  function automatic logic [15:0] baud_div(input logic [4:0] code);
    case (code)
      5'h06:   return 16'(CLK_HZ / 19200);
      5'h07:   return 16'(CLK_HZ / 38400);
      5'h08:   return 16'(CLK_HZ / 57600);
      5'h09:   return 16'(CLK_HZ / 115200);
      default: return 16'(CLK_HZ / 9600);
    endcase
  endfunction

  assign div      = baud_div(cfg_r.line_setup[4:0]);
  assign req_addr = {rxb_r[2], rxb_r[3]};
  assign req_val  = {rxb_r[4], rxb_r[5]};
  // Silence is 3.5 characters plus the end-of-query time.
  assign sil_lim  = 24'(`T35_BIT_TIMES * div) + 24'(cfg_r.delays[15:8] * MS_CYCLES);
  assign frame_ok = rx_n_r == `REQ_BYTES && !rx_bad_r && rx_crc_r == 16'h0000 &&
                    {8'h00, rxb_r[0]} == cfg_r.node_addr;

  // The character engine for the line.
  rtu_serial_port #(.DIV_W(16)) port_u (
    .clk        (MCLK),
    .rst_n      (RST_N),
    .div        (div),
    .frame_mode (cfg_r.line_setup[6:5]),
    .rxd        (rxd_s2_r),
    .rx_valid   (rx_valid),
    .rx_data    (rx_data),
    .rx_err     (rx_err),
    .tx_start   (tx_go_r),
    .tx_data    (tx_byte_r),
    .tx_busy    (tx_busy),
    .txd        (TXD)
  );

  // Two flip-flops bring the receive pin into the clock domain.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
    end else begin
      rxd_s1_r <= RXD;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  // Decodes a finished request into a reply kind, a code and a possible write.
  always_comb begin
    ex_kind = rtu_cfg_pkg::RSP_EXC;
    ex_code = `EXC_BAD_FN;
    ex_wr   = 1'b0;
    if (rxb_r[1] == `FN_READ_HOLD) begin
      if (req_val == 16'h0000 || req_val > `MAX_READ_WORDS) ex_code = `EXC_BAD_VALUE;
      else if (17'(req_addr) + 17'(req_val) > 17'(`PDU_OF(`REG_CHAN0_DATA) + NCHAN))
        ex_code = `EXC_BAD_ADDR;
      else ex_kind = rtu_cfg_pkg::RSP_READ;
    end else if (rxb_r[1] == `FN_WRITE_ONE) begin
      if (req_addr > 16'(`PDU_OF(`REG_DELAYS))) ex_code = `EXC_BAD_ADDR;
      else if (!wr_ok(req_addr, req_val)) ex_code = `EXC_BAD_VALUE;
      else begin
        ex_kind = rtu_cfg_pkg::RSP_ECHO;
        ex_wr   = 1'b1;
      end
    end
  end

  // Reply byte at the current index; the check word follows the body, low byte first.
  always_comb begin
    logic [5:0]  k;
    logic [15:0] w;
    k = idx_r - 6'h3;
    w = reg_read(req_addr + {11'h000, k[5:1]});
    if (idx_r == len_r)                 nxt_byte = tx_crc_r[7:0];
    else if (idx_r > len_r)             nxt_byte = tx_crc_r[15:8];
    else if (kind_r == rtu_cfg_pkg::RSP_ECHO) nxt_byte = rxb_r[idx_r[2:0]];
    else if (idx_r == 6'h0)             nxt_byte = rxb_r[0];
    else if (idx_r == 6'h1)
      nxt_byte = (kind_r == rtu_cfg_pkg::RSP_EXC) ? (rxb_r[1] | `FN_EXC_FLAG) : rxb_r[1];
    else if (idx_r == 6'h2)
      nxt_byte = (kind_r == rtu_cfg_pkg::RSP_EXC) ? code_r : {req_val[6:0], 1'b0};
    else                                nxt_byte = k[0] ? w[7:0] : w[15:8];
  end

  // Settings: defaults at reset, restored from the store, changed by accepted writes.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r      <= '{`RST_DELAYS, `RST_LINE_SETUP, `RST_NODE_ADDR};
      NV_SAVE    <= 1'b0;
      NV_CFG_OUT <= '{`RST_DELAYS, `RST_LINE_SETUP, `RST_NODE_ADDR};
    end else begin
      NV_SAVE <= 1'b0;
      if (st_r == rtu_cfg_pkg::ST_EXEC && frame_ok && ex_wr) begin
        // A write is handed to the store at once so it survives power loss.
        case (req_addr[1:0])
          2'h0:    begin cfg_r.node_addr  <= req_val; NV_CFG_OUT <= '{cfg_r.delays, cfg_r.line_setup, req_val}; end
          2'h1:    begin cfg_r.line_setup <= req_val; NV_CFG_OUT <= '{cfg_r.delays, req_val, cfg_r.node_addr}; end
          default: begin cfg_r.delays     <= req_val; NV_CFG_OUT <= '{req_val, cfg_r.line_setup, cfg_r.node_addr}; end
        endcase
        NV_SAVE <= 1'b1;
      end else if (NV_LOAD) begin
        cfg_r      <= NV_CFG_IN;
        NV_CFG_OUT <= NV_CFG_IN;
      end
    end
  end

  // Conversion pacing and result buffer.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      conv_tmr_r  <= 32'h0000_0000;
      ADC_START   <= 1'b0;
      ADC_CHAN    <= 2'h0;
      conv_cnt_r  <= 8'h00;
      last_chan_r <= 3'h0;
      for (int i = 0; i < NCHAN; i++) data_r[i] <= 16'h0000;
    end else begin
      ADC_START <= 1'b0;
      if (conv_tmr_r == 32'(CONV_CYCLES - 1)) begin
        conv_tmr_r <= 32'h0000_0000;
        ADC_START  <= 1'b1;
        ADC_CHAN   <= (ADC_CHAN == 2'(NCHAN - 1)) ? 2'h0 : ADC_CHAN + 2'h1;
      end else begin
        conv_tmr_r <= conv_tmr_r + 32'h0000_0001;
      end
      if (ADC_DONE) begin
        data_r[ADC_CHAN] <= ADC_RESULT;
        conv_cnt_r       <= conv_cnt_r + 8'h01;
        last_chan_r      <= {1'b0, ADC_CHAN};
      end
    end
  end

  // Request gathering, decision, delay and reply.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r      <= rtu_cfg_pkg::ST_RX;
      rx_n_r    <= 4'h0;
      rx_bad_r  <= 1'b0;
      rx_crc_r  <= `CRC_INIT;
      tmr_r     <= 24'h000000;
      kind_r    <= rtu_cfg_pkg::RSP_EXC;
      code_r    <= 8'h00;
      len_r     <= 6'h0;
      idx_r     <= 6'h0;
      tx_crc_r  <= `CRC_INIT;
      tx_go_r   <= 1'b0;
      tx_byte_r <= 8'h00;
      TX_EN     <= 1'b0;
      for (int i = 0; i < 8; i++) rxb_r[i] <= 8'h00;
    end else begin
      tx_go_r <= 1'b0;
      case (st_r)
        rtu_cfg_pkg::ST_RX: begin
          if (rx_valid) begin
            // Each character restarts the silence timer.
            tmr_r    <= 24'h000000;
            rx_crc_r <= crc_step(rx_crc_r, rx_data);
            if (rx_n_r < `REQ_BYTES) rxb_r[rx_n_r[2:0]] <= rx_data;
            else rx_bad_r <= 1'b1;
            if (rx_n_r <= `REQ_BYTES) rx_n_r <= rx_n_r + 4'h1;
            if (rx_err) rx_bad_r <= 1'b1;
          end else if (rx_n_r != 4'h0) begin
            if (tmr_r >= sil_lim) st_r <= rtu_cfg_pkg::ST_EXEC;
            else tmr_r <= tmr_r + 24'h000001;
          end
        end
        rtu_cfg_pkg::ST_EXEC: begin
          rx_n_r   <= 4'h0;
          rx_bad_r <= 1'b0;
          rx_crc_r <= `CRC_INIT;
          tmr_r    <= 24'h000000;
          kind_r   <= ex_kind;
          code_r   <= ex_code;
          len_r    <= (ex_kind == rtu_cfg_pkg::RSP_READ) ? 6'(6'h3 + {req_val[4:0], 1'b0}) :
                      (ex_kind == rtu_cfg_pkg::RSP_ECHO) ? 6'h6 : 6'h3;
          idx_r    <= 6'h0;
          tx_crc_r <= `CRC_INIT;
          // A foreign or damaged request is dropped without a word.
          st_r     <= frame_ok ? rtu_cfg_pkg::ST_WAIT : rtu_cfg_pkg::ST_RX;
        end
        rtu_cfg_pkg::ST_WAIT: begin
          // The master's transceiver gets the response delay to let go of the line.
          if (tmr_r >= 24'(cfg_r.delays[7:0] * MS_CYCLES)) begin
            st_r  <= rtu_cfg_pkg::ST_SEND;
            TX_EN <= 1'b1;
          end else tmr_r <= tmr_r + 24'h000001;
        end
        rtu_cfg_pkg::ST_SEND: begin
          if (!tx_busy && !tx_go_r) begin
            if (idx_r == len_r + 6'h2) st_r <= rtu_cfg_pkg::ST_DRAIN;
            else begin
              tx_go_r   <= 1'b1;
              tx_byte_r <= nxt_byte;
              idx_r     <= idx_r + 6'h1;
              if (idx_r < len_r) tx_crc_r <= crc_step(tx_crc_r, nxt_byte);
            end
          end
        end
        rtu_cfg_pkg::ST_DRAIN: begin
          // The driver stays on until the last stop bit has left.
          if (!tx_busy) begin
            TX_EN <= 1'b0;
            st_r  <= rtu_cfg_pkg::ST_RX;
          end
        end
        default: st_r <= rtu_cfg_pkg::ST_RX;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: dv/rtu_sensor_node_monitor.sv
// Port checker for the sensor node, bound to every instance of it.
// Assumes no reply silence is shorter than 3.5 characters at the fastest line rate.
`default_nettype none
module rtu_sensor_node_monitor #(
  parameter int CLK_HZ      = 40000000,
  parameter int MS_CYCLES   = 40000,
  parameter int CONV_CYCLES = 1600000
) (
  input wire logic                 MCLK,
  input wire logic                 RST_N,
  input wire logic                 RXD,
  input wire logic                 TXD,
  input wire logic                 TX_EN,
  input wire logic                 ADC_START,
  input wire logic [1:0]           ADC_CHAN,
  input wire logic                 NV_LOAD,
  input wire logic                 NV_SAVE,
  input wire rtu_cfg_pkg::cfg_type NV_CFG_IN,
  input wire rtu_cfg_pkg::cfg_type NV_CFG_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T35_MIN = 39 * (CLK_HZ / 115200);  // Shortest end-of-request silence.
  int quiet_r;  // Cycles the receive line has stayed high.
  int conv_r;   // Cycles since the last conversion start.
  // Silence and conversion spacing counters.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      quiet_r <= 0;
      conv_r  <= CONV_CYCLES;
    end else begin
      quiet_r <= RXD ? quiet_r + 1 : 0;
      conv_r  <= ADC_START ? 1 : conv_r + 1;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  chk_conv_spacing: assert property (ADC_START |-> conv_r >= CONV_CYCLES - 1)
    else $error("conversions started too close together");
  chk_chan_range: assert property (ADC_CHAN != 2'h3)
    else $error("channel select out of range");
  chk_chan_hold: assert property (!ADC_START |-> ADC_CHAN == $past(ADC_CHAN))
    else $error("channel changed without a start");
  chk_txd_idle: assert property (!TX_EN |-> TXD)
    else $error("transmit line not idle while driver off");
  chk_start_bit: assert property ($rose(TX_EN) |-> TXD ##1 TXD ##1 !TXD)
    else $error("start bit not right after driver enable");
  chk_reply_delay: assert property ($rose(TX_EN) |-> quiet_r >= T35_MIN
    + (NV_CFG_OUT.delays[7:0] + NV_CFG_OUT.delays[15:8]) * MS_CYCLES)
    else $error("reply started before silence and delays ran");
  chk_load_copy: assert property (NV_LOAD |=> NV_CFG_OUT == $past(NV_CFG_IN))
    else $error("restored settings not taken");
  chk_cfg_cause: assert property ($changed(NV_CFG_OUT) |-> $past(NV_LOAD) || NV_SAVE)
    else $error("settings changed without cause");
endmodule
bind rtu_sensor_node rtu_sensor_node_monitor #(.CLK_HZ(CLK_HZ), .MS_CYCLES(MS_CYCLES),
  .CONV_CYCLES(CONV_CYCLES)) u_mon (.MCLK(MCLK), .RST_N(RST_N), .RXD(RXD), .TXD(TXD),
  .TX_EN(TX_EN), .ADC_START(ADC_START), .ADC_CHAN(ADC_CHAN), .NV_LOAD(NV_LOAD), .NV_SAVE(NV_SAVE),
  .NV_CFG_IN(NV_CFG_IN), .NV_CFG_OUT(NV_CFG_OUT));
`default_nettype wire

// file: dv/rtu_host_model.sv
// Bus master model: sends query bytes and collects reply bytes.
// Assumes the line is biased high whenever the node's driver is off.
`default_nettype none
module rtu_host_model #(
  parameter int BIT = 347
) (
  input  wire logic clk,
  output logic      line_out,
  input  wire logic txd,
  input  wire logic tx_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic line;  // Level the host sees on the pair.
  assign line = tx_en ? txd : 1'b1;
  initial line_out = 1'b1;
  // Sends one 8N1 character, least significant bit first.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out = f[i];
      repeat (BIT) @(posedge clk);
      #1;
    end
  endtask
  // Takes one character; ok stays low on timeout or a bad stop bit.
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (line && n < 60000) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      #1;
      b[i] = line;
    end
    repeat (BIT) @(posedge clk);
    #1;
    ok = (n < 60000) && line;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Top bench: restores settings, then queries the node for a buffered value.
// Assumes the host model and converter model below stand for the far side.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK = 0, RST_N = 0, RXD, TXD, TX_EN, ADC_START, ADC_DONE = 0, NV_LOAD = 0, NV_SAVE;
  logic [1:0] ADC_CHAN;
  logic [15:0] ADC_RESULT = 16'h0000;
  rtu_cfg_pkg::cfg_type NV_CFG_IN = '0, NV_CFG_OUT;
  logic adc_pend = 0;  // Conversion waiting to complete.
  int n_errors = 0, num_checks = 0, cycles = 0, saves = 0;
  always #12.5 MCLK = ~MCLK;
  // The node is told half the real clock rate, so bits take fewer cycles and the run is short.
  rtu_sensor_node #(.CLK_HZ(20000000), .MS_CYCLES(20), .CONV_CYCLES(200)) uut (.MCLK(MCLK),
    .RST_N(RST_N),
    .RXD(RXD), .TXD(TXD), .TX_EN(TX_EN), .ADC_START(ADC_START), .ADC_CHAN(ADC_CHAN),
    .ADC_DONE(ADC_DONE), .ADC_RESULT(ADC_RESULT), .NV_LOAD(NV_LOAD), .NV_CFG_IN(NV_CFG_IN),
    .NV_SAVE(NV_SAVE), .NV_CFG_OUT(NV_CFG_OUT));
  rtu_host_model #(.BIT(173)) host (.clk(MCLK), .line_out(RXD), .txd(TXD), .tx_en(TX_EN));
  // Converter answers each start one cycle later with a per-channel value.
  always @(posedge MCLK) begin
    #1;
    ADC_DONE = adc_pend;
    ADC_RESULT = 16'h1230 | {14'h0000, ADC_CHAN};
    adc_pend = ADC_START;
    saves += NV_SAVE;
    if (++cycles == 95000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic check(string what, logic [47:0] exp, logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] crc_add(logic [15:0] c, logic [7:0] b);
    c ^= {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction
  // Sends one request of function, address and value or count with its check word.
  task automatic send_req(logic [7:0] node, logic [7:0] fn, logic [15:0] addr, logic [15:0] val);
    logic [7:0] q [6];
    logic [15:0] c;
    q = '{node, fn, addr[15:8], addr[7:0], val[15:8], val[7:0]};
    c = 16'hffff;
    foreach (q[i]) begin
      c = crc_add(c, q[i]);
      host.send_byte(q[i]);
    end
    host.send_byte(c[7:0]);
    host.send_byte(c[15:8]);
  endtask
  // Takes a reply of n bytes; the last two are the check word worked out here.
  task automatic expect_reply(logic [7:0] e [8], int n);
    logic [7:0] b;
    logic [15:0] c;
    logic ok;
    c = 16'hffff;
    for (int i = 0; i < n - 2; i++) c = crc_add(c, e[i]);
    {e[n - 1], e[n - 2]} = c;
    for (int i = 0; i < n; i++) begin
      host.get_byte(b, ok);
      check("reply_byte", {39'h0, ok, e[i]}, {39'h0, ok, b});
      check("reply_ok", 1, ok);
    end
  endtask
  // Reset values and a power-up restore selecting node 5 at 115200, 8N1.
  task automatic t_restore;
    check("cfg_reset", {16'h0003, 16'h0035, 16'h0001}, NV_CFG_OUT);
    check("tx_reset", 48'h2, {46'h0, TXD, TX_EN});
    NV_CFG_IN = {16'h0003, 16'h0069, 16'h0005};
    NV_LOAD = 1;
    @(posedge MCLK);
    #1;
    NV_LOAD = 0;
    @(posedge MCLK);
    #1;
    check("cfg_load", {16'h0003, 16'h0069, 16'h0005}, NV_CFG_OUT);
  endtask
  // A query for the old address must get no reply.
  task automatic t_other_node;
    int seen;
    seen = 0;
    send_req(8'h01, 8'h03, 16'd49, 16'h0001);
    repeat (7200) begin
      @(posedge MCLK);
      #1;
      seen += TX_EN;
    end
    check("foreign_reply", 0, seen);
  endtask
  // Reads channel 1 data (register 40050) from the buffer.
  task automatic t_read_chan;
    logic [7:0] e [8];
    e = '{8'h05, 8'h03, 8'h02, 8'h12, 8'h31, 8'h00, 8'h00, 8'h00};
    send_req(8'h05, 8'h03, 16'd49, 16'h0001);
    expect_reply(e, 7);
  endtask
  // Writes a response delay of 4; the node echoes the request and hands it to the store.
  task automatic t_write;
    logic [7:0] e [8];
    e = '{8'h05, 8'h06, 8'h00, 8'h02, 8'h00, 8'h04, 8'h00, 8'h00};
    repeat (200) @(posedge MCLK);
    #1;
    send_req(8'h05, 8'h06, 16'd2, 16'h0004);
    expect_reply(e, 8);
    check("nv_save_count", 1, saves);
    check("cfg_saved", {16'h0004, 16'h0069, 16'h0005}, NV_CFG_OUT);
  endtask
  task automatic final_report;
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge MCLK);
    #1;
    RST_N = 1;
    t_restore();
    t_other_node();
    t_read_chan();
    t_write();
    final_report();
  end
endmodule
`default_nettype wire
